// File: include/t2ccr_consts.vh
// Constants for the timer 2 compare/capture/reload block.
// Assumes a 32-bit APB slave port with byte addresses.
`ifndef T2CCR_CONSTS_VH
`define T2CCR_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define T2CCR_OFF_CTRL      8'h00
`define T2CCR_OFF_COUNT     8'h04
`define T2CCR_OFF_RELOAD    8'h08
`define T2CCR_OFF_CHMODE    8'h0C
`define T2CCR_OFF_PORT      8'h10
`define T2CCR_OFF_STATUS    8'h14
`define T2CCR_OFF_CCV0      8'h20
`define T2CCR_OFF_CCV1      8'h24
`define T2CCR_OFF_CCV2      8'h28
`define T2CCR_OFF_CCV3      8'h2C

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define T2CCR_CTRL_RUN      0
`define T2CCR_CTRL_PRESC    1
`define T2CCR_CTRL_RLD      2

// ----------------------------------------
// Field layouts
// ----------------------------------------
`define T2CCR_MODE_W        3
`define T2CCR_PORT_SHD_LSB  4
`define T2CCR_ST_CAP_LSB    4
`define T2CCR_ST_OVF        8

// ----------------------------------------
// Channel modes
// ----------------------------------------
`define T2CCR_MODE_OFF      3'h0
`define T2CCR_MODE_CMP0     3'h1
`define T2CCR_MODE_CMP1     3'h2
`define T2CCR_MODE_CAP0     3'h3
`define T2CCR_MODE_CAP1     3'h4

// ----------------------------------------
// Reset values and count limit
// ----------------------------------------
`define T2CCR_RST_CTRL      3'h0
`define T2CCR_RST_COUNT     16'h0000
`define T2CCR_RST_RELOAD    16'h0000
`define T2CCR_RST_CHMODE    12'h000
`define T2CCR_RST_CCV       16'h0000
`define T2CCR_COUNT_MAX     16'hFFFF

`endif

// File: hdl/t2ccr_chan.v
// One compare/capture channel of the timer 2 block.
// Assumes the count and overflow come from the timer in the top module.
`timescale 1ns/1ps
`default_nettype none
`include "t2ccr_consts.vh"

module t2ccr_chan (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [2:0]  mode_i,
    input  wire [15:0] count_i,
    input  wire        ovf_i,
    input  wire        port_wr_i,
    input  wire        port_bit_i,
    input  wire        ccv_wr_i,
    input  wire [1:0]  ccv_strb_i,
    input  wire [15:0] ccv_wdata_i,
    input  wire        pin_i,
    output reg  [15:0] ccv_o,
    output reg         out_latch_o,
    output reg         shadow_o,
    output wire        cmp_evt_o,
    output wire        cap_evt_o
);
    reg  pin_d;
    reg  match_d;
    wire is_cmp = (mode_i == `T2CCR_MODE_CMP0) || (mode_i == `T2CCR_MODE_CMP1);
    wire match = is_cmp && (count_i == ccv_o);                     // [R3]
    wire cap_ext = (mode_i == `T2CCR_MODE_CAP0) && pin_i && !pin_d;
    wire cap_sw = (mode_i == `T2CCR_MODE_CAP1) && ccv_wr_i && ccv_strb_i[0];
    wire next_shadow = port_wr_i ? port_bit_i : shadow_o;

    assign cmp_evt_o = match && !match_d;
    assign cap_evt_o = cap_ext || cap_sw;

    always @(posedge clk_i) begin
        if (rst_i) begin
            ccv_o       <= `T2CCR_RST_CCV;
            out_latch_o <= 1'b0;
            shadow_o    <= 1'b0;
            pin_d       <= 1'b0;
            match_d     <= 1'b0;
        end else begin
            pin_d   <= pin_i;
            match_d <= match;
            // ----------------------------------------
            // Compare/capture value
            // ----------------------------------------
            if (cap_ext || cap_sw) begin
                ccv_o <= count_i;                                  // [R5] [R15] [R16]
            end else if (ccv_wr_i) begin
                if (ccv_strb_i[0])
                    ccv_o[7:0] <= ccv_wdata_i[7:0];
                if (ccv_strb_i[1])
                    ccv_o[15:8] <= ccv_wdata_i[15:8];
            end
            // ----------------------------------------
            // Port latch pair
            // ----------------------------------------
            case (mode_i)
                `T2CCR_MODE_CMP0: begin
                    // Bus path cut off; timer events only
                    if (ovf_i)
                        out_latch_o <= 1'b0;                       // [R7] [R8] [R9]
                    else if (match)
                        out_latch_o <= 1'b1;                       // [R6] [R4]
                end
                `T2CCR_MODE_CMP1: begin
                    shadow_o <= next_shadow;                       // [R10] [R13]
                    if (match)
                        out_latch_o <= next_shadow;                // [R11] [R12] [R18]
                end
                `T2CCR_MODE_OFF: begin
                    shadow_o <= next_shadow;
                    out_latch_o <= next_shadow;
                end
                default: begin
                    shadow_o <= next_shadow;
                end
            endcase
        end
    end
endmodule // t2ccr_chan

`default_nettype wire

// File: hdl/t2ccr_top.v
// Timer 2 with four compare/capture/reload channels, APB slave.
// Assumes clk_i is the machine-cycle clock and pins are synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "t2ccr_consts.vh"

// Summary of operation
// [R1] 16-bit up-counter, high and low byte
// [R2] Prescaler: count every or every second cycle
// [R3] Compare value vs count; match drives pin, request
// [R4] Four compare outputs usable as PWM
// [R5] Four capture inputs latch the count
// [R6] Compare mode 0: match sets output high
// [R7] Compare mode 0: overflow clears output low
// [R8] Compare mode 0: bus disconnected from latch
// [R9] Compare mode 0: port writes ignored
// [R10] Compare mode 1: software sets both edges
// [R11] Compare mode 1: latches transparent during match
// [R12] Mode 1 write during match updates both
// [R13] Read-modify-write uses the shadow latch
// [R14] Plain port read returns pin level
// [R15] Capture mode 0: pin event copies count
// [R16] Capture mode 1: low-byte write copies count
// [R17] Reload function modulates timer cycle length
// [R18] Mode 1 match copies shadow to output
// [R19] Reload enabled: overflow loads reload value
// [R20] Each channel mode selected independently
module t2ccr_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    input  wire [3:0]  pstrb_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire [3:0]  cc_pin_i,
    output wire [3:0]  cc_o,
    output reg  [3:0]  cc_oe_o,
    output reg  [3:0]  cmp_req_o,
    output reg  [3:0]  cap_req_o
);

    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    reg  [2:0]  ctrl;
    reg  [15:0] count;
    reg  [15:0] reload;
    reg  [11:0] chmode;
    reg  [3:0]  cmp_flag;
    reg  [3:0]  cap_flag;
    reg         ovf_flag;
    reg         presc_phase;

    wire [15:0] ccv0;
    wire [15:0] ccv1;
    wire [15:0] ccv2;
    wire [15:0] ccv3;
    wire [3:0]  shadow;
    wire [3:0]  cmp_evt;
    wire [3:0]  cap_evt;
    wire [63:0] ccv_all;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire setup   = psel_i && !penable_i;
    wire access  = psel_i && penable_i && pready_o;
    wire wr      = access && pwrite_i;
    wire wr_ctrl = wr && (paddr_i == `T2CCR_OFF_CTRL);
    wire wr_cnt  = wr && (paddr_i == `T2CCR_OFF_COUNT);
    wire wr_rld  = wr && (paddr_i == `T2CCR_OFF_RELOAD);
    wire wr_mode = wr && (paddr_i == `T2CCR_OFF_CHMODE);
    wire wr_port = wr && (paddr_i == `T2CCR_OFF_PORT) && pstrb_i[0];
    wire wr_stat = wr && (paddr_i == `T2CCR_OFF_STATUS) && pstrb_i[1:0] != 2'b00;
    wire [3:0] wr_ccv;

    assign wr_ccv[0] = wr && (paddr_i == `T2CCR_OFF_CCV0);
    assign wr_ccv[1] = wr && (paddr_i == `T2CCR_OFF_CCV1);
    assign wr_ccv[2] = wr && (paddr_i == `T2CCR_OFF_CCV2);
    assign wr_ccv[3] = wr && (paddr_i == `T2CCR_OFF_CCV3);
    assign ccv_all   = {ccv3, ccv2, ccv1, ccv0};

    // ----------------------------------------
    // Prescaler and timer
    // ----------------------------------------
    // Tick is an enable, never a derived clock
    wire run  = ctrl[`T2CCR_CTRL_RUN];
    wire tick = run && (!ctrl[`T2CCR_CTRL_PRESC] || presc_phase);  // [R2]
    wire ovf  = tick && (count == `T2CCR_COUNT_MAX);

    always @(posedge clk_i) begin
        if (rst_i) begin
            presc_phase <= 1'b0;
        end else if (!run) begin
            presc_phase <= 1'b0;
        end else begin
            presc_phase <= !presc_phase;                           // [R2]
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            count <= `T2CCR_RST_COUNT;
        end else if (wr_cnt) begin
            // Software load wins over a tick in the same cycle
            if (pstrb_i[0])
                count[7:0] <= pwdata_i[7:0];
            if (pstrb_i[1])
                count[15:8] <= pwdata_i[15:8];
        end else if (ovf) begin
            if (ctrl[`T2CCR_CTRL_RLD])
                count <= reload;                                   // [R17] [R19]
            else
                count <= `T2CCR_RST_COUNT;
        end else if (tick) begin
            count <= count + 16'h0001;                             // [R1]
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl   <= `T2CCR_RST_CTRL;
            reload <= `T2CCR_RST_RELOAD;
            chmode <= `T2CCR_RST_CHMODE;
        end else begin
            if (wr_ctrl && pstrb_i[0])
                ctrl <= pwdata_i[2:0];
            if (wr_rld && pstrb_i[0])
                reload[7:0] <= pwdata_i[7:0];
            if (wr_rld && pstrb_i[1])
                reload[15:8] <= pwdata_i[15:8];
            if (wr_mode && pstrb_i[0])
                chmode[7:0] <= pwdata_i[7:0];                      // [R20]
            if (wr_mode && pstrb_i[1])
                chmode[11:8] <= pwdata_i[11:8];
        end
    end

    // ----------------------------------------
    // Channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_chan
            wire [15:0] ccv_q;
            t2ccr_chan u_chan (
                .clk_i       (clk_i),
                .rst_i       (rst_i),
                .mode_i      (chmode[3*g +: 3]),                   // [R20]
                .count_i     (count),
                .ovf_i       (ovf),
                .port_wr_i   (wr_port),
                .port_bit_i  (pwdata_i[g]),
                .ccv_wr_i    (wr_ccv[g]),
                .ccv_strb_i  (pstrb_i[1:0]),
                .ccv_wdata_i (pwdata_i[15:0]),
                .pin_i       (cc_pin_i[g]),
                .ccv_o       (ccv_q),
                .out_latch_o (cc_o[g]),
                .shadow_o    (shadow[g]),
                .cmp_evt_o   (cmp_evt[g]),
                .cap_evt_o   (cap_evt[g])
            );
        end
    endgenerate

    assign ccv0 = g_chan[0].ccv_q;
    assign ccv1 = g_chan[1].ccv_q;
    assign ccv2 = g_chan[2].ccv_q;
    assign ccv3 = g_chan[3].ccv_q;

    // ----------------------------------------
    // Pin drive and event requests
    // ----------------------------------------
    // Capture channels release the pin so it can be driven from outside
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cc_oe_o   <= 4'h0;
            cmp_req_o <= 4'h0;
            cap_req_o <= 4'h0;
        end else begin
            for (i = 0; i < 4; i = i + 1) begin
                cc_oe_o[i] <= (chmode[3*i +: 3] != `T2CCR_MODE_CAP0) &&
                              (chmode[3*i +: 3] != `T2CCR_MODE_CAP1);
            end
            cmp_req_o <= cmp_evt;                                  // [R3]
            cap_req_o <= cap_evt;
        end
    end

    // ----------------------------------------
    // Sticky status, write one to clear
    // ----------------------------------------
    // A new event in the clearing cycle wins
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmp_flag <= 4'h0;
            cap_flag <= 4'h0;
            ovf_flag <= 1'b0;
        end else begin
            cmp_flag <= (cmp_flag & ~(wr_stat ? pwdata_i[3:0] : 4'h0)) | cmp_evt;
            cap_flag <= (cap_flag & ~(wr_stat ? pwdata_i[7:4] : 4'h0)) | cap_evt;
            ovf_flag <= (ovf_flag & ~(wr_stat && pwdata_i[`T2CCR_ST_OVF])) | ovf;
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    reg [31:0] next_rdata;
    reg        next_err;
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (paddr_i)
            `T2CCR_OFF_CTRL: begin
                next_rdata[2:0] = ctrl;
            end
            `T2CCR_OFF_COUNT: begin
                next_rdata[15:0] = count;                          // [R1]
            end
            `T2CCR_OFF_RELOAD: begin
                next_rdata[15:0] = reload;
            end
            `T2CCR_OFF_CHMODE: begin
                next_rdata[11:0] = chmode;
            end
            `T2CCR_OFF_PORT: begin
                next_rdata[3:0] = cc_pin_i;                        // [R14]
                next_rdata[7:4] = shadow;                          // [R13]
            end
            `T2CCR_OFF_STATUS: begin
                next_rdata[3:0] = cmp_flag;
                next_rdata[7:4] = cap_flag;
                next_rdata[`T2CCR_ST_OVF] = ovf_flag;
            end
            `T2CCR_OFF_CCV0: begin
                next_rdata[15:0] = ccv_all[15:0];
            end
            `T2CCR_OFF_CCV1: begin
                next_rdata[15:0] = ccv_all[31:16];
            end
            `T2CCR_OFF_CCV2: begin
                next_rdata[15:0] = ccv_all[47:32];
            end
            `T2CCR_OFF_CCV3: begin
                next_rdata[15:0] = ccv_all[63:48];
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    // Ready rises for the access phase only: zero wait states
    always @(posedge clk_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= setup;
            if (setup) begin
                prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
                pslverr_o <= next_err;
            end else if (access) begin
                prdata_o  <= 32'h0000_0000;
                pslverr_o <= 1'b0;
            end
        end
    end

endmodule // t2ccr_top

`default_nettype wire

// File: dv/t2ccr_properties.sv
// Port-level checks for the timer 2 compare/capture block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module t2ccr_properties (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [3:0]  cc_oe_o,
    input wire logic [3:0]  cmp_req_o,
    input wire logic [3:0]  cap_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Bus phases
    // ----------------------------------------
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_access;
        psel_i && penable_i;
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ready_after_setup: assert property (s_setup ##1 s_access |-> pready_o)
        else $error("no ready in access cycle");
    a_ready_in_access: assert property (pready_o |-> s_access)
        else $error("ready outside access cycle");
    a_ready_single: assert property (pready_o |=> !pready_o)
        else $error("ready held two cycles");
    a_err_with_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0)
        else $error("error without ready or with data");
    a_unmapped_err: assert property (psel_i && !penable_i && paddr_i > 8'h2C |=> pslverr_o)
        else $error("unmapped address not refused");
    a_write_data_zero: assert property (pready_o && pwrite_i |-> prdata_o == 32'h0)
        else $error("read data on a write");
    a_cmp_req_single: assert property (cmp_req_o != 4'h0 |=> (cmp_req_o & $past(cmp_req_o)) == 4'h0)
        else $error("compare request longer than one cycle");
    a_cap_req_single: assert property (cap_req_o != 4'h0 |=> (cap_req_o & $past(cap_req_o)) == 4'h0)
        else $error("capture request longer than one cycle");
    a_cap_undriven: assert property (cap_req_o != 4'h0 |-> (cap_req_o & cc_oe_o) == 4'h0)
        else $error("capture on a driven line");
endmodule // t2ccr_properties
`default_nettype wire

// File: dv/t2ccr_pins.sv
// Model of the four multifunction port lines outside the block.
// Assumes pull-ups on every line, as on quasi-bidirectional ports.
`timescale 1ns/1ps
`default_nettype none
module t2ccr_pins (
    input  wire logic [3:0] cc_i,
    input  wire logic [3:0] oe_i,
    input  wire logic [3:0] ext_i,
    input  wire logic [3:0] ext_en_i,
    output var  logic [3:0] pin_o
);
    // Released lines not driven from outside float up to the pull-up level, never hold old data
    always_comb
        for (int k = 0; k < 4; k++)
            pin_o[k] = oe_i[k] ? cc_i[k] : (ext_en_i[k] ? ext_i[k] : 1'b1);
endmodule // t2ccr_pins
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the timer 2 block over APB.
// Assumes the pin model beside it and binds the port checker.
`timescale 1ns/1ps
`default_nettype none
`include "t2ccr_consts.vh"
module testbench;
    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  ext     = 4'h0;
    logic [3:0]  ext_en  = 4'h4;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [3:0]  cc_pin, cc, cc_oe, cmp_req, cap_req;
    int          n_errors = 0;
    int          checked  = 0;
    int          cyc      = 0;
    int          t0;

    always #5 clk_i = ~clk_i;

    t2ccr_top uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cc_pin_i(cc_pin),
        .cc_o(cc), .cc_oe_o(cc_oe), .cmp_req_o(cmp_req), .cap_req_o(cap_req));
    t2ccr_pins u_pins (.cc_i(cc), .oe_i(cc_oe), .ext_i(ext), .ext_en_i(ext_en), .pin_o(cc_pin));

    task summarize;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc > 4000) begin
            n_errors++;
            summarize();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Idle cycle first, so no strobe is set twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (n == 20)
            n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wreq(input logic cap, input int i);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((cap ? cap_req[i] : cmp_req[i]) !== 1'b1 && n < 300);
        if (n == 300)
            n_errors++;
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, `T2CCR_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `T2CCR_OFF_COUNT, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        $display("test reset_regs done");
        // Count set before modes so no stray match at zero
        apb(1'b1, `T2CCR_OFF_COUNT, 32'h0000FFF0);
        apb(1'b1, `T2CCR_OFF_RELOAD, 32'h0000FFF0);
        apb(1'b1, `T2CCR_OFF_CCV0, 32'h0000FFF8);
        apb(1'b1, `T2CCR_OFF_CCV1, 32'h0000FFF4);
        // Ch0 cmp0, ch1 cmp1, ch2 cap0, ch3 cap1
        apb(1'b1, `T2CCR_OFF_CHMODE, 32'h000008D1);
        apb(1'b1, `T2CCR_OFF_PORT, 32'h00000003);
        apb(1'b0, `T2CCR_OFF_PORT, 32'h0);
        chk(rd & 32'h3F, 32'h28);
        chk(cc_oe, 32'h3);
        apb(1'b1, `T2CCR_OFF_CTRL, 32'h5);
        wreq(1'b0, 0);
        t0 = cyc;
        repeat (2) @(posedge clk_i);
        chk(cc[0], 32'h1);
        chk(cc[1], 32'h1);
        repeat (8) @(posedge clk_i);
        chk(cc[0], 32'h0);
        wreq(1'b0, 0);
        chk(cyc - t0, 32'd16);
        apb(1'b1, `T2CCR_OFF_PORT, 32'h0);
        wreq(1'b0, 1);
        chk(cc[1], 32'h0);
        apb(1'b1, `T2CCR_OFF_CTRL, 32'h7);
        // Pulse from the last full-rate match is still pending; skip it
        wreq(1'b0, 0);
        wreq(1'b0, 0);
        t0 = cyc;
        wreq(1'b0, 0);
        chk(cyc - t0, 32'd32);
        $display("test compare done");
        apb(1'b1, `T2CCR_OFF_CTRL, 32'h0);
        apb(1'b1, `T2CCR_OFF_COUNT, 32'h00001234);
        apb(1'b0, `T2CCR_OFF_COUNT, 32'h0);
        chk(rd, 32'h00001234);
        ext[2] <= 1'b1;
        wreq(1'b1, 2);
        apb(1'b0, `T2CCR_OFF_CCV2, 32'h0);
        chk(rd, 32'h00001234);
        apb(1'b1, `T2CCR_OFF_CCV3, 32'h000000AB);
        apb(1'b0, `T2CCR_OFF_CCV3, 32'h0);
        chk(rd, 32'h00001234);
        apb(1'b0, `T2CCR_OFF_PORT, 32'h0);
        chk(rd[2], 32'h1);
        apb(1'b0, `T2CCR_OFF_STATUS, 32'h0);
        chk(rd, 32'h000001C3);
        apb(1'b1, `T2CCR_OFF_STATUS, 32'h000001FF);
        apb(1'b0, `T2CCR_OFF_STATUS, 32'h0);
        chk(rd, 32'h00000000);
        // Reload off: overflow wraps to zero, three ticks from FFFE
        apb(1'b1, `T2CCR_OFF_COUNT, 32'h0000FFFE);
        apb(1'b1, `T2CCR_OFF_CTRL, 32'h1);
        apb(1'b1, `T2CCR_OFF_CTRL, 32'h0);
        apb(1'b0, `T2CCR_OFF_COUNT, 32'h0);
        chk(rd, 32'h00000001);
        $display("test capture done");
        summarize();
    end
endmodule // testbench

bind t2ccr_top t2ccr_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .cc_oe_o(cc_oe_o), .cmp_req_o(cmp_req_o),
    .cap_req_o(cap_req_o));
`default_nettype wire
